/* File: core/typec_cc_detect.sv */
`timescale 1ns/100ps
module typec_cc_detect #(
  parameter int TOGGLE_CYCLES = typec_cc_pkg::TOGGLE_CYC,
  parameter int DEBOUNCE_CYCLES = typec_cc_pkg::DEBOUNCE_CYC,
  // identity value is arbitrary
  parameter logic [7:0] DEVICE_ID = 8'hA5
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [1:0] addr_sel_i,
  input wire logic [1:0] port_sel_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] cc1_lvl_i,
  input wire logic [1:0] cc2_lvl_i,
  input wire logic bus_power_sense_i,
  output logic cc_src_en_o,
  output logic cc_pd_en_o,
  output logic [1:0] cc_cur_lvl_o,
  output logic host_alert_n_oe_o,
  output logic attach_flag_n_oe_o,
  output logic charge_level_lo_n_oe_o,
  output logic charge_level_hi_n_oe_o,
  output logic audio_accessory_n_oe_o
);
  import typec_cc_pkg::*;

  if (TOGGLE_CYCLES < 4 || TOGGLE_CYCLES > 65535) begin : g_chk_tog
    $error("toggle period out of range");
  end
  if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 65535) begin : g_chk_deb
    $error("debounce out of range");
  end

  localparam logic [15:0] TOG_PER = 16'(TOGGLE_CYCLES);
  localparam logic [15:0] DEB_LEN = 16'(DEBOUNCE_CYCLES);

  typedef struct packed {
    conn_t st;
    logic [15:0] tmr;
    logic en;
    logic [7:0] ctrl;
    logic [7:0] flags;
    logic [7:0] stat;
    logic pend;
    logic i2c_rst;
    logic audio;
    logic debug;
    logic [1:0] cap;
    logic src_en;
    logic pd_en;
    logic [1:0] cur;
    logic attach_oe;
    logic lo_oe;
    logic hi_oe;
    logic aud_oe;
    logic alert_oe;
  } top_t;

  localparam top_t TOP_RST = '{st: UNATT_SNK, ctrl: CTRL_RST, pd_en: 1'b1, default: '0};

  top_t st_q, st_d;
  cc_reg_if rg ();

  logic en_edge, pin_mode, drp, try_src;
  logic [1:0] role, cur;
  logic [15:0] snk_cyc;
  logic snk_seen, one_rd, both_rd, both_ra, src_seen;
  logic att, det, chg;

  function automatic logic is_attached(input conn_t s);
    return s inside {ATT_SNK, ATT_SRC, ATT_ACC};
  endfunction : is_attached

  function automatic logic [15:0] sink_share(input logic [15:0] per,
                                             input logic [1:0] r,
                                             input logic ts);
    logic [31:0] p;
    logic [31:0] pct;
    pct = 32'd50;
    if (r == ROLE_DRP2) pct = ts ? 32'(100 - TRY_PCT) : 32'(TRY_PCT);
    p = 32'(per) * pct;
    return 16'(p / 32'd100);
  endfunction : sink_share

  function automatic logic [1:0] max_lvl(input logic [1:0] a, input logic [1:0] b);
    return (a > b) ? a : b;
  endfunction : max_lvl

  function automatic logic [15:0] inc16(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : 16'(v + 16'h1);
  endfunction : inc16

  cc_i2c_slave u_i2c (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i || st_q.i2c_rst),
    .bus_on_i(!pin_mode),
    .addr_hi_i(addr_sel_i == TRI_HIGH),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .rg(rg.slave)
  );

  always_comb begin
    unique case (rg.ptr)
      REG_ID: rg.rdata = DEVICE_ID;
      REG_CTRL: rg.rdata = st_q.ctrl;
      REG_FLAG: rg.rdata = st_q.flags;
      REG_STAT: rg.rdata = st_q.stat;
      default: rg.rdata = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.i2c_rst = 1'b0;
    st_d.en = enable_i;
    en_edge = enable_i ^ st_q.en;
    att = 1'b0;
    det = 1'b0;
    pin_mode = (addr_sel_i != TRI_LOW) && (addr_sel_i != TRI_HIGH);
    // role pin decode in pin mode
    if (pin_mode) begin
      unique case (port_sel_i)
        TRI_LOW: role = ROLE_SNK;
        TRI_HIGH: role = ROLE_SRC;
        default: role = ROLE_DRP2;
      endcase
      try_src = 1'b0;
      cur = CUR_DEF;
    end else begin
      role = st_q.ctrl[CTL_ROLE +: 2];
      try_src = st_q.ctrl[CTL_TRY_SRC];
      cur = st_q.ctrl[CTL_CUR +: 2];
    end
    drp = role[1];
    // biased sink share of toggle period
    snk_cyc = sink_share(TOG_PER, role, try_src);
    snk_seen = bus_power_sense_i && ((cc1_lvl_i != CC_OPEN) || (cc2_lvl_i != CC_OPEN));
    one_rd = (cc1_lvl_i == CC_RD) ^ (cc2_lvl_i == CC_RD);
    both_rd = (cc1_lvl_i == CC_RD) && (cc2_lvl_i == CC_RD);
    both_ra = (cc1_lvl_i == CC_RA) && (cc2_lvl_i == CC_RA);
    src_seen = one_rd || both_rd || both_ra;

    if (rg.wr_stb && rg.ptr == REG_CTRL) st_d.ctrl = rg.wdata;
    if (rg.rd_stb && rg.ptr == REG_FLAG) begin
      st_d.flags = 8'h00;
      st_d.pend = 1'b0;
    end

    // serial port reset on enable edge
    if (en_edge) st_d.i2c_rst = 1'b1;

    if (!enable_i || en_edge) begin
      st_d.st = UNATT_SNK;
      st_d.tmr = 16'h0;
      st_d.audio = 1'b0;
      st_d.debug = 1'b0;
      st_d.cap = 2'h0;
      if (en_edge && is_attached(st_q.st)) det = 1'b1;
    end else begin
      unique case (st_q.st)
        UNATT_SNK: begin
          st_d.audio = 1'b0;
          st_d.debug = 1'b0;
          st_d.cap = 2'h0;
          st_d.tmr = inc16(st_q.tmr);
          if (snk_seen && role != ROLE_SRC) begin
            st_d.st = DEB_SNK;
            st_d.tmr = 16'h0;
          end else if (role == ROLE_SRC || (drp && st_q.tmr >= snk_cyc)) begin
            st_d.st = UNATT_SRC;
            st_d.tmr = 16'h0;
          end
        end
        DEB_SNK: begin
          st_d.tmr = inc16(st_q.tmr);
          if (!snk_seen) begin
            st_d.st = UNATT_SNK;
            st_d.tmr = 16'h0;
          end else if (st_q.tmr >= DEB_LEN) begin
            st_d.st = ATT_SNK;
            att = 1'b1;
          end
        end
        ATT_SNK: begin
          st_d.cap = max_lvl(cc1_lvl_i, cc2_lvl_i);
          if (!bus_power_sense_i) begin
            st_d.st = UNATT_SNK;
            st_d.tmr = 16'h0;
            st_d.cap = 2'h0;
            det = 1'b1;
          end
        end
        UNATT_SRC: begin
          st_d.tmr = inc16(st_q.tmr);
          if (src_seen && role != ROLE_SNK) begin
            st_d.st = DEB_SRC;
            st_d.tmr = 16'h0;
          end else if (role == ROLE_SNK || (drp && st_q.tmr >= 16'(TOG_PER - snk_cyc))) begin
            st_d.st = UNATT_SNK;
            st_d.tmr = 16'h0;
          end
        end
        DEB_SRC: begin
          st_d.tmr = inc16(st_q.tmr);
          if (!src_seen) begin
            st_d.st = UNATT_SRC;
            st_d.tmr = 16'h0;
          end else if (st_q.tmr >= DEB_LEN) begin
            att = 1'b1;
            st_d.st = (both_ra || both_rd) ? ATT_ACC : ATT_SRC;
            st_d.audio = both_ra;
            st_d.debug = both_rd;
          end
        end
        ATT_SRC: if (!one_rd) begin
          st_d.st = UNATT_SRC;
          st_d.tmr = 16'h0;
          det = 1'b1;
        end
        ATT_ACC: if (st_q.audio ? !both_ra : !both_rd) begin
          st_d.st = UNATT_SRC;
          st_d.tmr = 16'h0;
          st_d.audio = 1'b0;
          st_d.debug = 1'b0;
          det = 1'b1;
        end
        default: st_d.st = UNATT_SNK;
      endcase
    end

    // events set flags, set beats clear
    if (att) st_d.flags[FLAG_ATT] = 1'b1;
    if (det) st_d.flags[FLAG_DET] = 1'b1;
    st_d.stat = {1'b0, st_d.cap, 1'b0, st_d.debug, st_d.audio,
                 (st_d.st == ATT_SNK) ? ST_ROLE_SNK :
                 (st_d.st inside {ATT_SRC, ATT_ACC}) ? ST_ROLE_SRC : 2'h0};
    chg = att || det || en_edge || (st_d.stat != st_q.stat);
    if (chg) st_d.pend = 1'b1;
    if (st_d.ctrl[CTL_MASK]) st_d.pend = 1'b0;
    st_d.alert_oe = st_d.pend;

    // sources in host states, else pull-downs
    st_d.src_en = enable_i && (st_d.st inside {UNATT_SRC, DEB_SRC, ATT_SRC, ATT_ACC});
    st_d.pd_en = !st_d.src_en;
    st_d.cur = cur;
    // attach flag only for host attach
    st_d.attach_oe = enable_i && (st_d.st == ATT_SRC);
    // charge outputs in pin sink mode
    st_d.lo_oe = enable_i && pin_mode && (st_d.st == ATT_SNK) && (st_d.cap >= CC_1A5);
    st_d.hi_oe = enable_i && pin_mode && (st_d.st == ATT_SNK) && (st_d.cap == CC_3A);
    st_d.aud_oe = enable_i && pin_mode && (st_d.st == ATT_ACC) && st_d.audio;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) st_q <= TOP_RST;
    else st_q <= st_d;
  end

  // open-drain data line only ever pulls low
  assign sda_o = 1'b0;
  assign cc_src_en_o = st_q.src_en;
  assign cc_pd_en_o = st_q.pd_en;
  assign cc_cur_lvl_o = st_q.cur;
  assign host_alert_n_oe_o = st_q.alert_oe;
  assign attach_flag_n_oe_o = st_q.attach_oe;
  assign charge_level_lo_n_oe_o = st_q.lo_oe;
  assign charge_level_hi_n_oe_o = st_q.hi_oe;
  assign audio_accessory_n_oe_o = st_q.aud_oe;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_alert_mask: assert property (
    st_q.ctrl[CTL_MASK] |-> !host_alert_n_oe_o)
    else $error("alert driven while masked");

  a_alert_event: assert property (
    (att || det) && !st_d.ctrl[CTL_MASK] |=> host_alert_n_oe_o && (st_q.flags != 8'h00))
    else $error("event did not raise alert");

  a_flag_clear: assert property (
    rg.rd_stb && rg.ptr == REG_FLAG && !att && !det && !en_edge
    |=> st_q.flags == 8'h00 && !host_alert_n_oe_o)
    else $error("flag read did not clear");

  a_edge_unatt: assert property (
    en_edge && !(rg.wr_stb && rg.ptr == REG_CTRL)
    |=> st_q.st == UNATT_SNK && $stable(st_q.ctrl) && st_q.i2c_rst)
    else $error("enable edge handling wrong");

  a_disable_pins: assert property (
    !st_q.en |-> cc_pd_en_o && !cc_src_en_o && !attach_flag_n_oe_o
                 && !charge_level_lo_n_oe_o && !charge_level_hi_n_oe_o
                 && !audio_accessory_n_oe_o)
    else $error("pins active while disabled");

  a_snk_needs_power: assert property (
    st_q.st == DEB_SNK && !bus_power_sense_i && enable_i && !en_edge
    |=> st_q.st == UNATT_SNK ##1 !attach_flag_n_oe_o)
    else $error("sink attach without bus power");

  a_acc_no_flag: assert property (
    st_q.st == ATT_ACC || st_q.st == ATT_SNK |-> !attach_flag_n_oe_o)
    else $error("attach flag on accessory or sink");

  a_pin_cur_def: assert property (
    pin_mode |=> cc_cur_lvl_o == CUR_DEF)
    else $error("pin mode advertises high current");

  a_attach_hold: assert property (
    st_q.st == ATT_SRC && one_rd && enable_i && !en_edge
    |=> st_q.st == ATT_SRC && cc_src_en_o)
    else $error("toggle left attached host state");

  c_att_snk: cover property (st_q.st == DEB_SNK ##1 st_q.st == ATT_SNK);
  c_att_src: cover property (st_q.st == DEB_SRC ##1 st_q.st == ATT_SRC);
  c_audio: cover property (st_q.st == ATT_ACC && st_q.audio);
  c_flag_read: cover property (rg.rd_stb && rg.ptr == REG_FLAG && st_q.flags != 8'h00);
endmodule : typec_cc_detect

/* File: core/typec_cc_pkg.sv */
// Overview of operation
// - floating select pin means pin control mode
// - alert low when flag or status changes
// - flag read clears flags, releases alert
// - mask bit holds alert released, ignores events
// - role field steers role, writable by host
// - reset initialises registers and serial state machine
// - host role sources current, device role pulls down
// - dual roles toggle until connection settles
// - second dual role biases toggle to 65 percent
// - host current level chosen by control field
// - device role reports partner current capability
// - attach flag low only for host-role device attach
// - audio and debug accessories reported in status
// - device role attach decided by bus power
// - disabled: indicators except alert released, both pins pulled down
// - serial port reset on enable edges and by chip reset
// - enable edge forces unattached sink, keeps control
// - enable high restarts attach detection
// - role pin picks device, dual, host
// - charge outputs encode partner current in pin mode
// - pin mode host advertises default current only
// - audio output low while audio accessory attached in pin mode
// - no offset byte, transfers start at first register
package typec_cc_pkg;
  localparam logic [2:0] REG_ID = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_FLAG = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam logic [2:0] REG_LAST = 3'h7;
  localparam int CTL_MASK = 0;
  localparam int CTL_ROLE = 1;
  localparam int CTL_CUR = 3;
  localparam int CTL_TRY_SRC = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int FLAG_ATT = 0;
  localparam int FLAG_DET = 1;
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_HIGH = 2'h1;
  localparam logic [1:0] ROLE_SNK = 2'h0;
  localparam logic [1:0] ROLE_SRC = 2'h1;
  localparam logic [1:0] ROLE_DRP2 = 2'h3;
  localparam logic [1:0] CUR_DEF = 2'h0;
  localparam logic [1:0] CC_OPEN = 2'h0;
  localparam logic [1:0] CC_RD = 2'h1;
  localparam logic [1:0] CC_RA = 2'h2;
  localparam logic [1:0] CC_1A5 = 2'h2;
  localparam logic [1:0] CC_3A = 2'h3;
  localparam logic [1:0] ST_ROLE_SNK = 2'h1;
  localparam logic [1:0] ST_ROLE_SRC = 2'h2;
  localparam logic [4:0] I2C_ADDR_LO = 5'h1D;
  localparam int TRY_PCT = 65;
  localparam int CLK_MHZ = 100;
  localparam int TOGGLE_PERIOD_US = 75;
  localparam int DEBOUNCE_US = 150;
  localparam int TOGGLE_CYC = TOGGLE_PERIOD_US * CLK_MHZ;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  typedef enum logic [2:0] {
    UNATT_SNK = 3'h0, DEB_SNK = 3'h1, ATT_SNK = 3'h3,
    UNATT_SRC = 3'h4, DEB_SRC = 3'h5, ATT_SRC = 3'h7, ATT_ACC = 3'h6
  } conn_t;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0, I2C_ADDR = 3'h1, I2C_AACK = 3'h3, I2C_WR = 3'h2,
    I2C_WACK = 3'h6, I2C_RD = 3'h7, I2C_RACK = 3'h5
  } i2c_st_t;
endpackage : typec_cc_pkg

/* File: core/cc_reg_if.sv */
`timescale 1ns/100ps
interface cc_reg_if;
  logic wr_stb;
  logic rd_stb;
  logic [2:0] ptr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr_stb, output rd_stb, output ptr, output wdata, input rdata);
  modport regs (input wr_stb, input rd_stb, input ptr, input wdata, output rdata);
endinterface : cc_reg_if

/* File: core/cc_i2c_slave.sv */
`timescale 1ns/100ps
module cc_i2c_slave (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic bus_on_i,
  input wire logic addr_hi_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  cc_reg_if.slave rg
);
  import typec_cc_pkg::*;
  typedef struct packed {
    i2c_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [2:0] ptr;
    logic oe;
    logic scl;
    logic sda;
    logic wr;
    logic rd;
  } i2c_t;
  i2c_t st_q, st_d;
  // line samples reset to the idle bus level, so no false edge follows reset
  localparam i2c_t I2C_RST = '{st: I2C_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
  logic rise, fall, start, stop;

  function automatic logic [2:0] ptr_next(input logic [2:0] p);
    return (p == REG_LAST) ? p : 3'(p + 3'h1);
  endfunction : ptr_next

  always_comb begin
    st_d = st_q;
    st_d.wr = 1'b0;
    st_d.rd = 1'b0;
    st_d.scl = scl_i;
    st_d.sda = sda_i;
    rise = !st_q.scl && scl_i;
    fall = st_q.scl && !scl_i;
    start = st_q.scl && scl_i && st_q.sda && !sda_i;
    stop = st_q.scl && scl_i && !st_q.sda && sda_i;
    if (!bus_on_i || stop) begin
      st_d.st = I2C_IDLE;
      st_d.oe = 1'b0;
    end else if (start) begin
      st_d.st = I2C_ADDR;
      st_d.cnt = 4'h0;
      st_d.ptr = REG_ID;
      st_d.oe = 1'b0;
    end else if (rise) begin
      if (st_q.st inside {I2C_ADDR, I2C_WR, I2C_RD}) st_d.cnt = 4'(st_q.cnt + 4'h1);
      if (st_q.st inside {I2C_ADDR, I2C_WR}) st_d.sh = {st_q.sh[6:0], sda_i};
      if (st_q.st == I2C_RACK) begin
        if (sda_i) st_d.st = I2C_IDLE;
        else st_d.ptr = ptr_next(st_q.ptr);
      end
    end else if (fall) begin
      unique case (st_q.st)
        I2C_IDLE: ;
        I2C_ADDR: if (st_q.cnt == 4'h8) begin
          // address bit 5 follows select pin
          if (st_q.sh[7:1] == {1'b0, addr_hi_i, I2C_ADDR_LO}) begin
            st_d.st = I2C_AACK;
            st_d.rw = st_q.sh[0];
            st_d.oe = 1'b1;
          end else st_d.st = I2C_IDLE;
        end
        I2C_AACK, I2C_RACK: begin
          st_d.cnt = 4'h0;
          if (st_q.rw) begin
            st_d.st = I2C_RD;
            st_d.sh = rg.rdata;
            st_d.rd = 1'b1;
            st_d.oe = !rg.rdata[7];
          end else begin
            st_d.st = I2C_WR;
            st_d.oe = 1'b0;
          end
        end
        I2C_WR: if (st_q.cnt == 4'h8) begin
          st_d.st = I2C_WACK;
          st_d.oe = 1'b1;
          st_d.wr = 1'b1;
        end
        I2C_WACK: begin
          st_d.st = I2C_WR;
          st_d.oe = 1'b0;
          st_d.cnt = 4'h0;
          st_d.ptr = ptr_next(st_q.ptr);
        end
        I2C_RD: if (st_q.cnt == 4'h8) begin
          st_d.st = I2C_RACK;
          st_d.oe = 1'b0;
        end else begin
          st_d.sh = {st_q.sh[6:0], 1'b0};
          st_d.oe = !st_q.sh[6];
        end
        default: st_d.st = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) st_q <= I2C_RST;
    else st_q <= st_d;
  end

  assign sda_oe_o = st_q.oe;
  assign rg.wr_stb = st_q.wr;
  assign rg.rd_stb = st_q.rd;
  assign rg.ptr = st_q.ptr;
  assign rg.wdata = st_q.sh;
endmodule : cc_i2c_slave

/* File: bench/cc_partner.sv */
`timescale 1ns/100ps
module cc_partner (
  input wire logic src_on_i,
  input wire logic [2:0] mode_i,
  input wire logic [1:0] cap_i,
  output logic [1:0] cc1_o,
  output logic [1:0] cc2_o,
  output logic vbus_o
);
  import typec_cc_pkg::*;
  // modes: 0 none, 1 sink, 2 source, 3 audio adapter, 4 debug
  always_comb begin
    cc1_o = CC_OPEN;
    cc2_o = CC_OPEN;
    // a source shows its current level only against a pull-down
    if (!src_on_i && mode_i == 3'h2) begin
      cc1_o = cap_i;
    end
    if (src_on_i) begin
      case (mode_i)
        3'h1: cc1_o = CC_RD;
        3'h3: begin
          cc1_o = CC_RA;
          cc2_o = CC_RA;
        end
        3'h4: begin
          cc1_o = CC_RD;
          cc2_o = CC_RD;
        end
        default: cc1_o = CC_OPEN;
      endcase
    end
  end
  // bus power only from a source facing our pull-downs
  assign vbus_o = (mode_i == 3'h2) && !src_on_i;
endmodule : cc_partner

/* File: bench/typec_cc_attach_detector_ctrl_tb_top.sv */
`timescale 1ns/100ps
module typec_cc_attach_detector_ctrl_tb_top;
  import typec_cc_pkg::*;
  localparam int TOG = 20;
  localparam int DEB = 4;
  // identity value is arbitrary
  localparam logic [7:0] DEV_ID = 8'h5C;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enable_i = 1'b0;
  logic [1:0] addr_sel_i = TRI_HIGH;
  logic [1:0] port_sel_i = 2'h0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sda_w;
  logic sda_o, sda_oe_o, bus_power_sense_i, cc_src_en_o, cc_pd_en_o;
  logic [1:0] cc1_lvl_i, cc2_lvl_i, cc_cur_lvl_o;
  logic host_alert_n_oe_o, attach_flag_n_oe_o, charge_level_lo_n_oe_o;
  logic charge_level_hi_n_oe_o, audio_accessory_n_oe_o;
  logic [2:0] pmode = 3'h0;
  logic [1:0] pcap = 2'h1;
  logic [1:0] c;
  logic [7:0] rv [4];
  logic ack, aok;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;
  always #5 core_clk_i = ~core_clk_i;
  // open drain: either side may pull the wire low
  assign sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);
  typec_cc_detect #(.TOGGLE_CYCLES(TOG), .DEBOUNCE_CYCLES(DEB), .DEVICE_ID(DEV_ID))
    i_typec_cc_detect (.core_clk_i(core_clk_i), .rst_i(rst_i), .enable_i(enable_i),
    .addr_sel_i(addr_sel_i), .port_sel_i(port_sel_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cc1_lvl_i(cc1_lvl_i), .cc2_lvl_i(cc2_lvl_i),
    .bus_power_sense_i(bus_power_sense_i), .cc_src_en_o(cc_src_en_o),
    .cc_pd_en_o(cc_pd_en_o), .cc_cur_lvl_o(cc_cur_lvl_o),
    .host_alert_n_oe_o(host_alert_n_oe_o), .attach_flag_n_oe_o(attach_flag_n_oe_o),
    .charge_level_lo_n_oe_o(charge_level_lo_n_oe_o),
    .charge_level_hi_n_oe_o(charge_level_hi_n_oe_o),
    .audio_accessory_n_oe_o(audio_accessory_n_oe_o));
  cc_partner i_cc_partner (.src_on_i(cc_src_en_o), .mode_i(pmode), .cap_i(pcap),
    .cc1_o(cc1_lvl_i), .cc2_o(cc2_lvl_i), .vbus_o(bus_power_sense_i));
  task automatic hp(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : hp
  function automatic logic [7:0] outs();
    return {1'b0, host_alert_n_oe_o, audio_accessory_n_oe_o, charge_level_hi_n_oe_o,
      charge_level_lo_n_oe_o, attach_flag_n_oe_o, cc_pd_en_o, cc_src_en_o};
  endfunction : outs
  // sink cycles seen in 220 clocks of toggling
  function automatic int drp(input int pct);
    return 220 * (TOG * pct / 100 + 1) / (TOG + 2);
  endfunction : drp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    hp(4);
    scl = 1'b1;
    hp(4);
    r = sda_w;
    scl = 1'b0;
  endtask : bitx
  task automatic start;
    sda_m = 1'b1;
    hp(4);
    scl = 1'b1;
    hp(4);
    sda_m = 1'b0;
    hp(4);
    scl = 1'b0;
  endtask : start
  task automatic stop;
    sda_m = 1'b0;
    hp(4);
    scl = 1'b1;
    hp(4);
    sda_m = 1'b1;
    hp(4);
  endtask : stop
  task automatic bytex(input logic [7:0] wb, input logic am, output logic [7:0] rb);
    for (int i = 7; i >= 0; i--) bitx(wb[i], rb[i]);
    bitx(am, ack);
    ack = ~ack;
  endtask : bytex
  // no offset byte: every transfer starts at the id register
  task automatic rd(input int n, input logic a);
    logic [7:0] d;
    start;
    bytex({1'b0, a, I2C_ADDR_LO, 1'b1}, 1'b1, d);
    aok = ack;
    for (int i = 0; i < n; i++) bytex(8'hFF, (i == n - 1), rv[i]);
    stop;
  endtask : rd
  task automatic wr(input logic [7:0] v);
    logic [7:0] d;
    start;
    bytex({1'b0, 1'b1, I2C_ADDR_LO, 1'b0}, 1'b1, d);
    bytex(8'h00, 1'b1, d);
    bytex(v, 1'b1, d);
    stop;
  endtask : wr
  task automatic tog(input int e);
    int n;
    n = 0;
    repeat (220) begin
      @(negedge core_clk_i);
      if (cc_pd_en_o === 1'b1) n++;
    end
    chk(8'((n > e - 4) && (n < e + 4)), 8'h01);
  endtask : tog
  task automatic re_en(input logic [1:0] p);
    enable_i = 1'b0;
    port_sel_i = p;
    hp(3);
    enable_i = 1'b1;
    hp(30);
  endtask : re_en
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    void'($urandom(5));
    hp(16);
    rst_i = 1'b0;
    hp(2);
    rd(4, 1'b1);
    chk(rv[0], DEV_ID);
    chk(rv[1], CTRL_RST);
    chk(rv[2] | rv[3], 8'h00);
    chk(outs(), 8'h02);
    rd(1, 1'b0);
    chk({7'h0, aok}, 8'h00);
    enable_i = 1'b1;
    hp(3);
    chk(outs() & 8'h40, 8'h40);
    rd(3, 1'b1);
    hp(2);
    chk(outs() & 8'h40, 8'h00);
    wr(8'h12);
    rd(2, 1'b1);
    chk(rv[1], 8'h12);
    pmode = 3'h1;
    hp(30);
    chk(outs(), 8'h45);
    chk({6'h0, cc_cur_lvl_o}, 8'h02);
    rd(4, 1'b1);
    chk(rv[2] & 8'h03, 8'h01);
    chk(rv[3] & 8'h0F, 8'h02);
    hp(2);
    chk(outs() & 8'h40, 8'h00);
    for (k = 0; k < 4; k++) begin
      c = 2'($urandom % 3);
      wr({3'h0, c, ROLE_SRC, 1'b0});
      hp(4);
      chk({6'h0, cc_cur_lvl_o}, {6'h0, c});
    end
    wr({3'h0, CUR_DEF, ROLE_SRC, 1'b1});
    pmode = 3'h0;
    hp(40);
    chk(outs(), 8'h01);
    wr(8'h00);
    pcap = 2'($urandom % 3) + 2'h1;
    // a source that leaves inside the debounce must not attach
    pmode = 3'h2;
    hp(2);
    pmode = 3'h0;
    hp(10);
    rd(4, 1'b1);
    chk(rv[3] & 8'h03, 8'h00);
    pmode = 3'h2;
    hp(40);
    rd(4, 1'b1);
    chk(rv[3] & 8'h63, {1'b0, pcap, 5'h01});
    chk(outs() & 8'h07, 8'h02);
    wr(8'h02);
    pmode = 3'h3;
    hp(40);
    rd(4, 1'b1);
    chk(rv[3] & 8'h0F, 8'h06);
    chk(outs() & 8'h04, 8'h00);
    pmode = 3'h4;
    hp(40);
    rd(4, 1'b1);
    chk(rv[3] & 8'h0F, 8'h0A);
    pmode = 3'h0;
    wr(8'h04);
    hp(10);
    tog(drp(50));
    wr(8'h06);
    tog(drp(TRY_PCT));
    wr(8'h26);
    tog(drp(100 - TRY_PCT));
    wr(8'h04);
    pmode = 3'h1;
    hp(100);
    tog(0);
    enable_i = 1'b0;
    hp(3);
    chk(outs(), 8'h42);
    rd(2, 1'b1);
    chk(rv[1], 8'h04);
    addr_sel_i = TRI_LOW;
    rd(1, 1'b0);
    chk({7'h0, aok}, 8'h01);
    addr_sel_i = 2'h2;
    rd(1, 1'b1);
    chk({7'h0, aok}, 8'h00);
    re_en(TRI_HIGH);
    chk(outs() & 8'h3F, 8'h05);
    chk({6'h0, cc_cur_lvl_o}, 8'h00);
    pmode = 3'h2;
    for (k = 1; k < 4; k++) begin
      pcap = 2'(k);
      re_en(TRI_LOW);
      chk(outs() & 8'h1F, (k == 3) ? 8'h1A : (k == 2) ? 8'h0A : 8'h02);
    end
    pmode = 3'h3;
    re_en(TRI_HIGH);
    chk(outs() & 8'h24, 8'h20);
    pmode = 3'h0;
    re_en(2'h2);
    tog(drp(TRY_PCT));
    close_out;
  end
endmodule : typec_cc_attach_detector_ctrl_tb_top
